// *** rtl/pseis_regs.vh ***
// Command codes, field positions and reset values of the interrupt summary block
`ifndef PSEIS_REGS_VH
`define PSEIS_REGS_VH

// Command codes of the management bus
`define PSEIS_CMD_SUMMARY      8'h00
`define PSEIS_CMD_MASK         8'h01
`define PSEIS_CMD_PWR_EVT      8'h02
`define PSEIS_CMD_PWR_EVT_COR  8'h03
`define PSEIS_CMD_DET_EVT      8'h04
`define PSEIS_CMD_DET_EVT_COR  8'h05
`define PSEIS_CMD_FLT_EVT      8'h06
`define PSEIS_CMD_FLT_EVT_COR  8'h07
`define PSEIS_CMD_STR_EVT      8'h08
`define PSEIS_CMD_STR_EVT_COR  8'h09
`define PSEIS_CMD_SUP_EVT      8'h0A
`define PSEIS_CMD_SUP_EVT_COR  8'h0B
`define PSEIS_CMD_GEN_MASK     8'h17
`define PSEIS_CMD_RESET        8'h1A

// Number of event registers feeding the summary
`define PSEIS_NUM_EVT          5
// Event register indices
`define PSEIS_EVT_PWR          0
`define PSEIS_EVT_DET          1
`define PSEIS_EVT_FLT          2
`define PSEIS_EVT_STR          3
`define PSEIS_EVT_SUP          4

// Summary bit positions
`define PSEIS_SUM_SUPPLY       7
`define PSEIS_SUM_START        6
`define PSEIS_SUM_CURRENT      5
`define PSEIS_SUM_CLASS        4
`define PSEIS_SUM_DETECT       3
`define PSEIS_SUM_DISCONNECT   2
`define PSEIS_SUM_PGOOD        1
`define PSEIS_SUM_PENABLE      0

// Field positions in control registers
`define PSEIS_GEN_IRQ_EN_BIT   7
`define PSEIS_RESET_CLR_BIT    7

// Reset values
`define PSEIS_MASK_RST         8'h80
`define PSEIS_GEN_MASK_RST     8'h80
`define PSEIS_EVT_RST          8'h00
`define PSEIS_UNMAPPED_DATA    8'h00

`endif

// *** rtl/pseis_event_reg.v ***
// Sticky event register with clear-on-read and global clear
`timescale 1ns/1ps
`default_nettype none
`include "pseis_regs.vh"

module pseis_event_reg (
  input  wire       clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire [7:0] set_in,
  input  wire       rd_clr,
  input  wire       glob_clr,
  output wire [7:0] flags
);

  reg  [7:0] flags_q;   // Sticky flags
  wire [7:0] flags_d;   // Next flags
  wire       clr_any;   // Any clear source

  assign clr_any = rd_clr | glob_clr;

  // Set wins over clear in the same cycle
  assign flags_d = (flags_q & ~{8{clr_any}}) | set_in;

  // Flag storage, frozen while clock enable is low
  always @(posedge clk) begin
    if (reset) begin
      flags_q <= `PSEIS_EVT_RST;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

`default_nettype wire

// *** rtl/pseis_interrupt_summary.v ***
// Interrupt summary register, mask registers and request pin of the PSE controller
// Behaviour
// [RULE_01] Summary is read-only byte at command 00h
// [RULE_02] Summary bits active high, one per class
// [RULE_03] Reading feeding event register clears its bit
// [RULE_04] Reset register bit 7 clears summary bits
// [RULE_05] Request needs mask bit and global enable
// [RULE_06] Bit 7 ORs supply faults, resets to one
// [RULE_07] Bit 6 ORs channel start-timeout faults
// [RULE_08] Bit 5 ORs overload and current-limit faults
// [RULE_09] Bit 4 ORs channel classification events
// [RULE_10] Bit 3 ORs channel detection events
// [RULE_11] Bit 2 ORs channel disconnect events
// [RULE_12] Bit 1 ORs channel power-good changes
// [RULE_13] Bit 0 ORs channel power-enable changes
// [RULE_14] Mask blocks pin only, summary still updates
// [RULE_15] Clear-on-read clears whole event register
// [RULE_16] Request pin active low level while pending
`timescale 1ns/1ps
`default_nettype none
`include "pseis_regs.vh"

module pseis_interrupt_summary (
  input  wire       clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire       cmd_valid,
  input  wire       cmd_write,
  input  wire [7:0] cmd_code,
  input  wire [7:0] cmd_wdata,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg        irq_n,
  input  wire [3:0] chan_power_good_change,
  input  wire [3:0] chan_power_enable_change,
  input  wire [3:0] chan_class_event,
  input  wire [3:0] chan_detect_event,
  input  wire [3:0] chan_disconnect_event,
  input  wire [3:0] chan_overload_flag,
  input  wire [1:0] pair_overload_flag,
  input  wire [3:0] chan_current_limit_flag,
  input  wire [3:0] chan_start_timeout_flag,
  input  wire       thermal_shutdown_flag,
  input  wire       digital_supply_undervolt,
  input  wire       digital_supply_warning,
  input  wire       power_supply_undervolt,
  input  wire       memory_fault_flag
);

  // Register bus model: one command per enabled cycle
  // Reads answer one cycle later through rd_valid
  // Writes take effect at the edge that takes them
  // No request is refused; unmapped codes read zero
  // Back-to-back commands are taken every cycle
  // Event inputs are sampled on every enabled edge
  // Clock enable low freezes every flop below

  // Reset value of the general mask register
  localparam [7:0] GEN_MASK_RST = `PSEIS_GEN_MASK_RST;

  // Control registers
  reg  [7:0] irq_mask_q;        // Per-class mask, one enables
  reg  [7:0] irq_mask_d;        // Next mask
  reg        global_irq_enable_q; // Global request enable
  reg        global_irq_enable_d; // Next global enable
  reg        supply_boot_q;     // Supply summary set from reset
  reg        supply_boot_d;     // Next boot flag

  // Command decode is purely combinational
  // Read and write requests need cmd_valid high
  // A low cmd_write marks a read
  // Decoded accesses
  wire       rd_req;            // Read command this cycle
  wire       wr_req;            // Write command this cycle
  wire       glob_clr;          // Global clear pulse
  reg  [`PSEIS_NUM_EVT-1:0] cor_hit; // Clear-on-read per register

  // Five bytes of eight flags, packed side by side
  // Index order follows the event register constants
  // Event register inputs and contents
  wire [8*`PSEIS_NUM_EVT-1:0] evt_set;   // Packed set vectors
  wire [8*`PSEIS_NUM_EVT-1:0] evt_flags; // Packed flag vectors
  wire [7:0] pwr_evt;           // Power event flags
  wire [7:0] det_evt;           // Detection event flags
  wire [7:0] flt_evt;           // Disconnect and overload flags
  wire [7:0] str_evt;           // Start and current-limit flags
  wire [7:0] sup_evt;           // Supply and pair overload flags

  // Live summary and the request it drives
  // Next read data is held in rd_data_d
  // Summary and request
  wire [7:0] summary;           // Live summary byte
  wire       irq_pending;       // Any enabled unmasked bit
  reg  [7:0] rd_data_d;         // Next read data

  assign rd_req = cmd_valid & ~cmd_write;
  assign wr_req = cmd_valid & cmd_write;

  // Global clear is never stored as a bit
  // Only the write cycle itself clears the flags
  // Reading the reset code back returns zero
  // Reset register bit 7 is a self-clearing strobe
  // [RULE_04] global clear strobe
  assign glob_clr = wr_req & (cmd_code == `PSEIS_CMD_RESET) &
                    cmd_wdata[`PSEIS_RESET_CLR_BIT];

  // Only the odd codes clear their register
  // Even codes read the same byte without side effect
  // Summary read at 00h never clears anything
  // Clear-on-read decode per event register
  always @* begin
    cor_hit = {`PSEIS_NUM_EVT{1'b0}};
    if (rd_req) begin
      case (cmd_code)
        `PSEIS_CMD_PWR_EVT_COR: begin
          cor_hit[`PSEIS_EVT_PWR] = 1'b1;
        end
        `PSEIS_CMD_DET_EVT_COR: begin
          cor_hit[`PSEIS_EVT_DET] = 1'b1;
        end
        `PSEIS_CMD_FLT_EVT_COR: begin
          cor_hit[`PSEIS_EVT_FLT] = 1'b1;
        end
        `PSEIS_CMD_STR_EVT_COR: begin
          cor_hit[`PSEIS_EVT_STR] = 1'b1;
        end
        `PSEIS_CMD_SUP_EVT_COR: begin
          cor_hit[`PSEIS_EVT_SUP] = 1'b1;
        end
        default: begin
          cor_hit = {`PSEIS_NUM_EVT{1'b0}};
        end
      endcase
    end
  end

  // Grouping of sources into five event bytes
  // Power: good change high nibble, enable change low
  // Detection: class high nibble, detect low
  // Fault: disconnect high nibble, overload low
  // Start: timeout high nibble, current limit low
  // Supply: pair overload bits 6:5, supply faults 4:0
  // Set vectors of the event registers
  assign evt_set[8*`PSEIS_EVT_PWR +: 8] = {chan_power_good_change,
                                           chan_power_enable_change};
  assign evt_set[8*`PSEIS_EVT_DET +: 8] = {chan_class_event, chan_detect_event};
  assign evt_set[8*`PSEIS_EVT_FLT +: 8] = {chan_disconnect_event, chan_overload_flag};
  assign evt_set[8*`PSEIS_EVT_STR +: 8] = {chan_start_timeout_flag,
                                           chan_current_limit_flag};
  assign evt_set[8*`PSEIS_EVT_SUP +: 8] = {1'b0, pair_overload_flag,
                                           thermal_shutdown_flag,
                                           digital_supply_undervolt,
                                           digital_supply_warning,
                                           power_supply_undervolt,
                                           memory_fault_flag};

  // Each byte keeps its flags until a clear-on-read or a global clear
  // A held event level keeps setting its flag
  // One sticky event register per source group
  genvar gi;
  generate
    for (gi = 0; gi < `PSEIS_NUM_EVT; gi = gi + 1) begin : g_evt
      // [RULE_15] whole register clears on read
      pseis_event_reg u_evt (
        .clk      (clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .set_in   (evt_set[8*gi +: 8]),
        .rd_clr   (cor_hit[gi]),
        .glob_clr (glob_clr),
        .flags    (evt_flags[8*gi +: 8])
      );
    end
  endgenerate

  assign pwr_evt = evt_flags[8*`PSEIS_EVT_PWR +: 8];
  assign det_evt = evt_flags[8*`PSEIS_EVT_DET +: 8];
  assign flt_evt = evt_flags[8*`PSEIS_EVT_FLT +: 8];
  assign str_evt = evt_flags[8*`PSEIS_EVT_STR +: 8];
  assign sup_evt = evt_flags[8*`PSEIS_EVT_SUP +: 8];

  // Summary is a live OR, not a second sticky copy
  // Hazard avoided: summary bits 6:0 never disagree with the event bytes
  // Bit 5 needs three bytes clear before it drops
  // Summary bits follow their feeding registers; bit 7 also follows the boot flag
  // [RULE_02] active-high class bits
  // [RULE_03] cleared through feeding register
  // [RULE_06] supply faults plus boot flag
  assign summary[`PSEIS_SUM_SUPPLY]     = |sup_evt[4:0] | supply_boot_q;
  // [RULE_07] start-timeout OR
  assign summary[`PSEIS_SUM_START]      = |str_evt[7:4];
  // [RULE_08] overload and limit OR
  assign summary[`PSEIS_SUM_CURRENT]    = |flt_evt[3:0] | |sup_evt[6:5] | |str_evt[3:0];
  // [RULE_09] classification OR
  assign summary[`PSEIS_SUM_CLASS]      = |det_evt[7:4];
  // [RULE_10] detection OR
  assign summary[`PSEIS_SUM_DETECT]     = |det_evt[3:0];
  // [RULE_11] disconnect OR
  assign summary[`PSEIS_SUM_DISCONNECT] = |flt_evt[7:4];
  // [RULE_12] power-good change OR
  assign summary[`PSEIS_SUM_PGOOD]      = |pwr_evt[7:4];
  // [RULE_13] power-enable change OR
  assign summary[`PSEIS_SUM_PENABLE]    = |pwr_evt[3:0];

  // Boot flag makes bit 7 read one after reset
  // It has no event input, so nothing sets it again
  // Boot flag clears with a supply clear-on-read at 0Bh or global clear
  always @* begin
    supply_boot_d = supply_boot_q;
    if (cor_hit[`PSEIS_EVT_SUP] | glob_clr) begin
      supply_boot_d = 1'b0;
    end
  end

  // Mask and general mask are the only bytes that store a write
  // Writes to the summary or event codes are ignored
  // Only bit 7 of the general mask is kept
  // Writable control registers
  always @* begin
    irq_mask_d          = irq_mask_q;
    global_irq_enable_d = global_irq_enable_q;
    if (wr_req) begin
      case (cmd_code)
        `PSEIS_CMD_MASK: begin
          irq_mask_d = cmd_wdata;
        end
        `PSEIS_CMD_GEN_MASK: begin
          global_irq_enable_d = cmd_wdata[`PSEIS_GEN_IRQ_EN_BIT];
        end
        default: begin
          irq_mask_d = irq_mask_q;
        end
      endcase
    end
  end

  // Mask gates the pin only, never the summary
  // Pin follows one edge behind the live summary
  // Request combines summary, mask and global enable
  // [RULE_05] mask and global enable gate
  // [RULE_14] mask only gates the pin
  assign irq_pending = global_irq_enable_q & |(summary & irq_mask_q);

  // Read data holds its last value between reads
  // Clear-on-read returns the flags before clearing
  // Same-cycle events stay set for the next read
  // Read data multiplexer, unmapped codes read zero
  always @* begin
    rd_data_d = rd_data;
    if (rd_req) begin
      case (cmd_code)
        // [RULE_01] summary at command 00h
        `PSEIS_CMD_SUMMARY: begin
          rd_data_d = summary;
        end
        `PSEIS_CMD_MASK: begin
          rd_data_d = irq_mask_q;
        end
        `PSEIS_CMD_PWR_EVT, `PSEIS_CMD_PWR_EVT_COR: begin
          rd_data_d = pwr_evt;
        end
        `PSEIS_CMD_DET_EVT, `PSEIS_CMD_DET_EVT_COR: begin
          rd_data_d = det_evt;
        end
        `PSEIS_CMD_FLT_EVT, `PSEIS_CMD_FLT_EVT_COR: begin
          rd_data_d = flt_evt;
        end
        `PSEIS_CMD_STR_EVT, `PSEIS_CMD_STR_EVT_COR: begin
          rd_data_d = str_evt;
        end
        `PSEIS_CMD_SUP_EVT, `PSEIS_CMD_SUP_EVT_COR: begin
          rd_data_d = sup_evt;
        end
        `PSEIS_CMD_GEN_MASK: begin
          rd_data_d = {global_irq_enable_q, 7'h00};
        end
        default: begin
          rd_data_d = `PSEIS_UNMAPPED_DATA;
        end
      endcase
    end
  end

  // All outputs leave flops, so no glitch on the pin
  // Reset releases the pin; it drops one edge later
  // Boot flag is unmasked by default
  // State and output flops, frozen while clock enable is low
  always @(posedge clk) begin
    if (reset) begin
      irq_mask_q          <= `PSEIS_MASK_RST;
      global_irq_enable_q <= GEN_MASK_RST[`PSEIS_GEN_IRQ_EN_BIT];
      supply_boot_q       <= 1'b1;
      rd_data             <= 8'h00;
      rd_valid            <= 1'b0;
      irq_n               <= 1'b1;
    end else if (clk_en) begin
      irq_mask_q          <= irq_mask_d;
      global_irq_enable_q <= global_irq_enable_d;
      supply_boot_q       <= supply_boot_d;
      rd_data             <= rd_data_d;
      rd_valid            <= rd_req;
      // [RULE_16] active-low level request
      irq_n               <= ~irq_pending;
    end
  end

endmodule

`default_nettype wire

// *** tb/pseis_checker.sv ***
// Port-level assertions of the interrupt summary block
`timescale 1ns/1ps
`default_nettype none
module pseis_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       irq_n,
  input wire logic [3:0] chan_power_good_change,
  input wire logic [3:0] chan_power_enable_change,
  input wire logic [3:0] chan_detect_event
);
  // Decoded requests and quiet inputs
  wire rd_req  = cmd_valid && !cmd_write && clk_en;
  wire wr_req  = cmd_valid && cmd_write && clk_en;
  wire pwr_q   = !(|chan_power_good_change) && !(|chan_power_enable_change);
  wire det_q   = !(|chan_detect_event);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Steps of multi-cycle behaviours
  sequence s_cor_pwr; rd_req && cmd_code == 8'h03 && pwr_q; endsequence
  sequence s_sum_rd; rd_req && cmd_code == 8'h00; endsequence
  sequence s_glb_clr; wr_req && cmd_code == 8'h1A && cmd_wdata[7] && det_q; endsequence
  sequence s_en_off; wr_req && cmd_code == 8'h17 && !cmd_wdata[7]; endsequence
  a_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  a_no_extra_valid: assert property (clk_en && !rd_req |=> !rd_valid)
    else $error("read valid without request");
  a_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved without read");
  a_detect_seen: assert property ((clk_en && !det_q) ##1 !cmd_valid ##1 s_sum_rd
    |=> rd_data[3]) else $error("detect summary missing");
  a_cor_clears: assert property (s_cor_pwr ##1 (pwr_q && !cmd_valid)
    ##1 (s_sum_rd and pwr_q) |=> rd_data[1:0] == 2'b00)
    else $error("power summary not cleared");
  a_glob_clear: assert property (s_glb_clr ##1 (det_q && !cmd_valid)
    ##1 (s_sum_rd and det_q) |=> !rd_data[3]) else $error("global clear missed");
  a_enable_gate: assert property (s_en_off ##1 (clk_en && !wr_req) |=> irq_n)
    else $error("request while disabled");
  a_release_cause: assert property ($rose(irq_n)
    |-> $past(cmd_valid) || $past(cmd_valid, 2) || !$past(clk_en, 2))
    else $error("request released without command");
endmodule
bind pseis_interrupt_summary pseis_checker u_chk (.clk, .reset, .clk_en, .cmd_valid, .cmd_write,
  .cmd_code, .cmd_wdata, .rd_data, .rd_valid, .irq_n, .chan_power_good_change,
  .chan_power_enable_change, .chan_detect_event);
`default_nettype wire

// *** tb/pseis_host_model.sv ***
// Host model issuing command-coded register accesses
`timescale 1ns/1ps
`default_nettype none
module pseis_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output var  logic       cmd_valid,
  output var  logic       cmd_write,
  output var  logic [7:0] cmd_code,
  output var  logic [7:0] cmd_wdata
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
  end
  // One request cycle; idle fields show inverted values so stale data is not trusted
  task automatic put(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
  endtask
  // Read with a bounded wait for the answer
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output bit ok);
    put(1'b0, c, 8'h00);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (rd_valid === 1'b1);
      d = rd_data;
      if (!ok) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/pseis_interrupt_summary_tb_top.sv ***
// Self-checking bench of the interrupt summary block
`timescale 1ns/1ps
`default_nettype none
module pseis_interrupt_summary_tb_top;
  logic        clk = 1'b0;      // 40 MHz clock
  logic        reset = 1'b1;    // Synchronous reset
  logic        en = 1'b1;       // Clock enable
  logic [38:0] ev = 39'h0;      // All event inputs, packed
  wire         cmd_valid, cmd_write, rd_valid, irq_n;
  wire  [7:0]  cmd_code, cmd_wdata, rd_data;
  int          n_mismatch = 0;
  int          compares = 0;
  always #12.5 clk = ~clk;
  pseis_host_model host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  pseis_interrupt_summary dut (.clk(clk), .reset(reset), .clk_en(en), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .irq_n(irq_n), .chan_power_good_change(ev[38:35]),
    .chan_power_enable_change(ev[34:31]), .chan_class_event(ev[30:27]),
    .chan_detect_event(ev[26:23]), .chan_disconnect_event(ev[22:19]),
    .chan_overload_flag(ev[18:15]), .pair_overload_flag(ev[14:13]),
    .chan_current_limit_flag(ev[12:9]), .chan_start_timeout_flag(ev[8:5]),
    .thermal_shutdown_flag(ev[4]), .digital_supply_undervolt(ev[3]),
    .digital_supply_warning(ev[2]), .power_supply_undervolt(ev[1]), .memory_fault_flag(ev[0]));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register read and compare
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    host.rd(c, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, d, exp);
      report_and_stop();
    end else begin
      chk(d, exp);
    end
  endtask
  // Two edges for a write or event to reach the request pin
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // One-cycle pulse on one event input
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 39'h0;
  endtask
  // Summary bit fed by each packed event position
  function automatic int cls(input int i);
    if (i > 34) cls = 1;
    else if (i > 30) cls = 0;
    else if (i > 26) cls = 4;
    else if (i > 22) cls = 3;
    else if (i > 18) cls = 2;
    else if (i > 8) cls = 5;
    else if (i > 4) cls = 6;
    else cls = 7;
  endfunction
  // Plain read keeps, clear-on-read empties one event byte
  task automatic evt_pair(input int i, input logic [7:0] c, input logic [7:0] exp);
    host.put(1'b1, 8'h1A, 8'h80);
    pulse(i);
    rd_chk(c, exp);
    rd_chk(c + 8'h01, exp);
    rd_chk(c + 8'h01, 8'h00);
    rd_chk(8'h00, 8'h00);
  endtask
  task automatic t_reset;
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h01, 8'h80);
    chk({7'h00, irq_n}, 8'h00);
    rd_chk(8'h0B, 8'h00);
    rd_chk(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_sources;
    for (int i = 0; i < 39; i++) begin
      host.put(1'b1, 8'h1A, 8'h80);
      rd_chk(8'h00, 8'h00);
      pulse(i);
      case (cls(i))
        7: rd_chk(8'h00, 8'h80);
        6: rd_chk(8'h00, 8'h40);
        5: rd_chk(8'h00, 8'h20);
        4: rd_chk(8'h00, 8'h10);
        3: rd_chk(8'h00, 8'h08);
        2: rd_chk(8'h00, 8'h04);
        1: rd_chk(8'h00, 8'h02);
        default: rd_chk(8'h00, 8'h01);
      endcase
    end
    $display("test sources done");
  endtask
  task automatic t_clear_on_read;
    host.put(1'b1, 8'h1A, 8'h80);
    pulse(35);
    pulse(23);
    rd_chk(8'h02, 8'h10);
    rd_chk(8'h03, 8'h10);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h00, 8'h08);
    $display("test clear on read done");
  endtask
  task automatic t_mask;
    settle();
    chk({7'h00, irq_n}, 8'h01);
    host.put(1'b1, 8'h01, 8'h08);
    settle();
    chk({7'h00, irq_n}, 8'h00);
    host.put(1'b1, 8'h17, 8'h00);
    settle();
    chk({7'h00, irq_n}, 8'h01);
    host.put(1'b1, 8'h17, 8'h80);
    settle();
    chk({7'h00, irq_n}, 8'h00);
    rd_chk(8'h01, 8'h08);
    host.put(1'b1, 8'h00, 8'hFF);
    rd_chk(8'h00, 8'h08);
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h05, 8'h01);
    settle();
    chk({7'h00, irq_n}, 8'h01);
    $display("test mask done");
  endtask
  // Clock enable low: events and writes are ignored
  task automatic t_freeze;
    @(posedge clk);
    en <= 1'b0;
    pulse(23);
    host.put(1'b1, 8'h01, 8'hFF);
    en <= 1'b1;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h08);
    settle();
    chk({7'h00, irq_n}, 8'h01);
    $display("test freeze done");
  endtask
  // Every event byte by plain and clear-on-read code
  task automatic t_event_regs;
    evt_pair(31, 8'h02, 8'h01);
    evt_pair(27, 8'h04, 8'h10);
    evt_pair(19, 8'h06, 8'h10);
    evt_pair(5, 8'h08, 8'h10);
    evt_pair(13, 8'h0A, 8'h20);
    $display("test event registers done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_sources();
    t_clear_on_read();
    t_mask();
    t_freeze();
    t_event_regs();
    report_and_stop();
  end
endmodule
`default_nettype wire
